// file: pmrs_pkg.sv
// Constants and types for the power mode and reset sequencer.
// Assumes a single 125 MHz clock domain and no software-visible bus.
package pmrs_pkg;
  // Port and dedicated input geometry
  localparam int unsigned PORT_BITS = 38;
  localparam int unsigned DED_IN_LO = 2;
  localparam int unsigned DED_IN_HI = 3;
  localparam int unsigned P3_BASE = 24;
  // Stop unlock key and its register reset value
  localparam logic [7:0] STOP_UNLOCK_KEY = 8'ha5;
  localparam logic [7:0] STOP_UNLOCK_RST = 8'h00;
  // Warm-up: time in microseconds, cycles at 8 ns clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WARMUP_US = 100;
  localparam int unsigned WARMUP_CYCLES = (WARMUP_US * 1000) / CLK_PERIOD_NS;
  // Dedicated input mask within the port vector
  localparam logic [PORT_BITS-1:0] DED_MASK =
    (38'h1 << (P3_BASE + DED_IN_LO)) | (38'h1 << (P3_BASE + DED_IN_HI));

  typedef enum logic [3:0] {
    ST_BACKUP = 4'b0001,
    ST_RESET  = 4'b0010,
    ST_RUN    = 4'b0100,
    ST_STOP   = 4'b1000
  } mode_type;
endpackage : pmrs_pkg

// file: pmrs_sync.sv
// Two-flip-flop synchroniser for asynchronous level inputs.
// Assumes inputs come from pins or analog monitors outside mclk.
`timescale 1ns/1ns
module pmrs_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage read only by the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : pmrs_sync

// file: power_mode_reset_sequencer.sv
// Mode sequencer: back-up, reset status, run and stop.
// Assumes pin, supply monitor and interrupt inputs are asynchronous;
// stop request and unlock writes come from the core on mclk.
`timescale 1ns/1ns
module power_mode_reset_sequencer
  import pmrs_pkg::*;
#(
  parameter int unsigned WARMUP_COUNT = pmrs_pkg::WARMUP_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic external_reset_pin_n,
  input wire logic supply_ok,
  input wire logic watchdog_overflow,
  input wire logic ext_irq,
  input wire logic stop_release_wake,
  input wire logic unlock_wr,
  input wire logic [7:0] unlock_wdata,
  input wire logic stop_exec,
  input wire logic [pmrs_pkg::PORT_BITS-1:0] port_cfg_out_en,
  input wire logic [pmrs_pkg::PORT_BITS-1:0] port_cfg_pullup,
  input wire logic [pmrs_pkg::PORT_BITS-1:0] port_data,
  output logic [pmrs_pkg::PORT_BITS-1:0] pin_out,
  output logic [pmrs_pkg::PORT_BITS-1:0] pin_oe,
  output logic [pmrs_pkg::PORT_BITS-1:0] pullup_en,
  output logic [pmrs_pkg::PORT_BITS-1:0] input_enable,
  output logic reg_init,
  output logic cpu_run,
  output logic stop_active,
  output logic [7:0] stop_unlock_register,
  output logic [3:0] mode_state
);
  import pmrs_pkg::*;

  initial begin
    if (WARMUP_COUNT < 1 || WARMUP_COUNT > 32'h00ffffff)
      $error("WARMUP_COUNT out of range");
  end

  localparam int unsigned CW = $clog2(WARMUP_COUNT + 1);

  // Asynchronous inputs, each through two flops
  logic [4:0] async_raw;
  logic [4:0] async_s;
  assign async_raw = {external_reset_pin_n, supply_ok, watchdog_overflow, ext_irq,
                      stop_release_wake};
  pmrs_sync #(.WIDTH(5), .INIT(5'h00)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din(async_raw),
    .dout(async_s)
  );

  wire pin_s = async_s[4];
  wire sup_s = async_s[3];
  wire wdt_s = async_s[2];
  wire irq_s = async_s[1];
  wire wake_s = async_s[0];

  mode_type state_ff, nxt_state;
  logic [CW-1:0] warm_ff, nxt_warm;
  logic pin_prev_ff;
  logic sup_prev_ff;
  logic [7:0] unlock_ff, nxt_unlock;
  logic [PORT_BITS-1:0] hold_oe_ff, hold_data_ff, hold_pu_ff;

  // Edge and level decode
  wire backup_cond = !pin_s || !sup_s;
  wire pin_rise = pin_s && !pin_prev_ff;
  wire sup_rise = sup_s && !sup_prev_ff;
  wire rst_event = pin_rise || sup_rise || wdt_s;
  wire warm_done = (warm_ff == CW'(WARMUP_COUNT - 1));
  wire stop_ok = stop_exec && (unlock_ff == STOP_UNLOCK_KEY);
  wire stop_exit = irq_s || wake_s;

  // Mode transitions; back-up has top priority
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BACKUP: begin
        if (!backup_cond && (pin_rise || sup_rise)) nxt_state = ST_RESET;
      end
      ST_RESET: begin
        if (warm_done) nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (rst_event) nxt_state = ST_RESET;
        else if (stop_ok) nxt_state = ST_STOP;
      end
      ST_STOP: begin
        if (rst_event) nxt_state = ST_RESET;
        else if (stop_exit) nxt_state = ST_RUN;
      end
      default: nxt_state = ST_BACKUP;
    endcase
    if (backup_cond) nxt_state = ST_BACKUP;
  end

  // Warm-up counter restarts on every entry into reset status
  assign nxt_warm = (nxt_state == ST_RESET && state_ff == ST_RESET && !rst_event)
                    ? warm_ff + CW'(1) : '0;

  // Unlock register cleared in back-up and reset status
  always_comb begin
    nxt_unlock = unlock_ff;
    if (nxt_state == ST_BACKUP || nxt_state == ST_RESET) nxt_unlock = STOP_UNLOCK_RST;
    else if (unlock_wr) nxt_unlock = unlock_wdata;
  end

  // Port drive per mode; dedicated inputs keep pull-ups in back-up and reset status
  wire in_stop = (nxt_state == ST_STOP);
  wire in_rst = (nxt_state == ST_BACKUP) || (nxt_state == ST_RESET);
  wire freeze = in_stop && (state_ff == ST_STOP);
  wire [PORT_BITS-1:0] nxt_oe = in_rst ? '0 : (freeze ? hold_oe_ff : port_cfg_out_en);
  wire [PORT_BITS-1:0] nxt_dat = in_rst ? '0 : (freeze ? hold_data_ff : port_data);
  wire [PORT_BITS-1:0] nxt_pu = in_rst ? DED_MASK
                                : (freeze ? hold_pu_ff : port_cfg_pullup);
  wire [PORT_BITS-1:0] nxt_ie = (nxt_state == ST_BACKUP) ? DED_MASK : '1;

  // State, counters and edge history
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= ST_BACKUP;
      warm_ff <= '0;
      pin_prev_ff <= 1'b0;
      sup_prev_ff <= 1'b0;
      unlock_ff <= STOP_UNLOCK_RST;
    end else begin
      state_ff <= nxt_state;
      warm_ff <= nxt_warm;
      pin_prev_ff <= pin_s;
      sup_prev_ff <= sup_s;
      unlock_ff <= nxt_unlock;
    end
  end

  // Port hold registers double as the port outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_oe_ff <= '0;
      hold_data_ff <= '0;
      hold_pu_ff <= DED_MASK;
      input_enable <= DED_MASK;
    end else begin
      hold_oe_ff <= nxt_oe;
      hold_data_ff <= nxt_dat;
      hold_pu_ff <= nxt_pu;
      input_enable <= nxt_ie;
    end
  end

  // Status outputs straight from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_init <= 1'b1;
      cpu_run <= 1'b0;
      stop_active <= 1'b0;
    end else begin
      reg_init <= in_rst;
      cpu_run <= (nxt_state == ST_RUN);
      stop_active <= in_stop;
    end
  end

  assign pin_oe = hold_oe_ff;
  assign pin_out = hold_data_ff;
  assign pullup_en = hold_pu_ff;
  assign stop_unlock_register = unlock_ff;
  assign mode_state = state_ff;
endmodule : power_mode_reset_sequencer

// file: pmrs_properties.sv
// Port checker for the mode sequencer.
// Bound into every sequencer; one mclk domain, srst sync high.
`timescale 1ns/1ns
module pmrs_properties
  import pmrs_pkg::*;
#(parameter int unsigned WARMUP_COUNT = 8) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic external_reset_pin_n,
  input wire logic supply_ok,
  input wire logic stop_exec,
  input wire logic [PORT_BITS-1:0] pin_out,
  input wire logic [PORT_BITS-1:0] pin_oe,
  input wire logic [PORT_BITS-1:0] pullup_en,
  input wire logic [PORT_BITS-1:0] input_enable,
  input wire logic reg_init,
  input wire logic [7:0] stop_unlock_register,
  input wire logic [3:0] mode_state
);
  // Wide enough for any warm-up count the sequencer accepts
  logic [31:0] wait_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Cycles in reset status; a counter, since warm-up is too long to unroll
  always_ff @(posedge mclk) begin
    if (srst) wait_ff <= 32'h0;
    else wait_ff <= (mode_state == 4'h2) ? wait_ff + 32'h1 : 32'h0;
  end
  low_backup_a: assert property ((!external_reset_pin_n || !supply_ok) [*5] |-> mode_state == 4'h1)
    else $error("no back-up while pin or supply low");
  bk_float_a: assert property (mode_state == 4'h1 |-> !pin_oe && input_enable == DED_MASK)
    else $error("back-up pins not floating");
  bk_pullup_a: assert property (mode_state == 4'h1 |-> pullup_en == DED_MASK)
    else $error("back-up pull-ups wrong");
  rst_float_a: assert property (mode_state == 4'h2 |-> !pin_oe && pullup_en == DED_MASK)
    else $error("reset status pins wrong");
  init_hold_a: assert property (mode_state[1:0] != 2'b00 |-> reg_init)
    else $error("registers not held at reset");
  warmup_a: assert property (mode_state == 4'h4 && $past(mode_state) == 4'h2 |-> wait_ff >= WARMUP_COUNT)
    else $error("run started before warm-up");
  stop_freeze_a: assert property (mode_state == 4'h8 && $past(mode_state) == 4'h8 |->
    $stable(pin_out) && $stable(pin_oe) && $stable(pullup_en)) else $error("ports moved in stop");
  stop_key_a: assert property (mode_state == 4'h8 && $past(mode_state) == 4'h4 |->
    $past(stop_exec) && $past(stop_unlock_register) == STOP_UNLOCK_KEY) else $error("bad stop entry");
endmodule : pmrs_properties
bind power_mode_reset_sequencer pmrs_properties #(.WARMUP_COUNT(WARMUP_COUNT)) chk_i (.*);

// file: pmrs_partner.sv
// Model of reset pin, supply monitor, watchdog and wake sources.
// Levels move just after a falling mclk edge and stay until redriven.
`timescale 1ns/1ns
module pmrs_partner (
  input wire logic mclk,
  output logic external_reset_pin_n,
  output logic supply_ok,
  output logic watchdog_overflow,
  output logic ext_irq,
  output logic stop_release_wake
);
  logic [4:0] lvl = 5'h00;
  assign {external_reset_pin_n, supply_ok, watchdog_overflow, ext_irq, stop_release_wake} = lvl;
  // Each level held at least two cycles so the synchronisers catch pulses
  task automatic drive(input logic [4:0] v);
    @(negedge mclk);
    lvl = v;
    repeat (2) @(negedge mclk);
  endtask : drive
endmodule : pmrs_partner

// file: test_power_mode_reset_sequencer.sv
// Random and corner tests of the mode sequencer with its source model.
// One mclk domain; the bench drives on the falling edge.
`timescale 1ns/1ns
module test_power_mode_reset_sequencer;
  import pmrs_pkg::*;
  logic mclk = 0, srst = 1, unlock_wr = 0, stop_exec = 0;
  logic [7:0] unlock_wdata = 8'h00;
  logic [PORT_BITS-1:0] port_cfg_out_en = '0, port_cfg_pullup = '0, port_data = '0, frozen;
  wire logic external_reset_pin_n, supply_ok, watchdog_overflow, ext_irq, stop_release_wake;
  wire logic [PORT_BITS-1:0] pin_out, pin_oe, pullup_en, input_enable;
  wire logic reg_init, cpu_run, stop_active;
  wire logic [7:0] stop_unlock_register;
  wire logic [3:0] mode_state;
  integer seed = 32'h3593;
  int fails = 0, compares = 0, n;
  logic [4:0] wake [3] = '{5'b11010, 5'b11001, 5'b11100};
  logic [4:0] upset [3] = '{5'b11100, 5'b10000, 5'b01000};
  always #4 mclk = ~mclk;
  pmrs_partner pt (.*);
  power_mode_reset_sequencer #(.WARMUP_COUNT(8)) uut (.*);
  // Mode a source pattern leads to: back-up beats watchdog beats wake
  function automatic logic [3:0] mode_for(input logic [4:0] v);
    return (!v[4] || !v[3]) ? 4'h1 : v[2] ? 4'h2 : 4'h4;
  endfunction : mode_for
  function automatic logic [3:0] stop_for(input logic [7:0] key);
    return (key == STOP_UNLOCK_KEY) ? 4'h8 : 4'h4;
  endfunction : stop_for
  task automatic chk(input string what, input logic [PORT_BITS-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Bounded wait for a mode; a miss ends the run
  task automatic wait_mode(input logic [3:0] m);
    for (n = 0; mode_state !== m && n < 40; n++) @(negedge mclk);
    chk("mode", m, mode_state);
    if (mode_state !== m) end_sim();
  endtask : wait_mode
  task automatic try_stop(input logic [7:0] key);
    @(negedge mclk);
    unlock_wr = 1;
    unlock_wdata = key;
    @(negedge mclk);
    unlock_wr = 0;
    stop_exec = 1;
    @(negedge mclk);
    stop_exec = 0;
    chk("stop entry", stop_for(key), mode_state);
  endtask : try_stop
  initial begin
    repeat (8) @(negedge mclk);
    srst = 0;
    chk("backup pullups", DED_MASK, pullup_en);
    chk("backup oe", '0, pin_oe);
    chk("backup init", 1'b1, reg_init);
    chk("backup inputs", DED_MASK, input_enable);
    pt.drive(5'b11000);
    wait_mode(4'h2);
    chk("reset pullups", DED_MASK, pullup_en);
    for (n = 0; mode_state === 4'h2 && n < 40; n++) @(negedge mclk);
    chk("warm-up cycles", 8, n);
    chk("run flag", 1'b1, cpu_run);
    port_cfg_out_en = PORT_BITS'({$random(seed), $random(seed)});
    port_cfg_pullup = PORT_BITS'({$random(seed), $random(seed)});
    try_stop(8'($random(seed)) & 8'hfe);
    try_stop(8'ha4);
    for (int i = 0; i < 3; i++) begin
      try_stop(STOP_UNLOCK_KEY);
      frozen = pin_out;
      port_data = PORT_BITS'({$random(seed), $random(seed)});
      port_cfg_out_en = ~port_cfg_out_en;
      repeat (4) @(negedge mclk);
      chk("stop data", frozen, pin_out);
      chk("stop held", 4'h8, mode_state);
      chk("stop flag", 1'b1, stop_active);
      chk("unlock value", STOP_UNLOCK_KEY, stop_unlock_register);
      pt.drive(wake[i]);
      wait_mode(mode_for(wake[i]));
      chk("unlock after wake", wake[i][2] ? STOP_UNLOCK_RST : STOP_UNLOCK_KEY, stop_unlock_register);
      pt.drive(5'b11000);
      wait_mode(4'h4);
    end
    for (int i = 0; i < 3; i++) begin
      pt.drive(upset[i]);
      wait_mode(mode_for(upset[i]));
      pt.drive(5'b11000);
      wait_mode(4'h4);
    end
    end_sim();
  end
endmodule : test_power_mode_reset_sequencer
